// File: hw/sia_regs.vh
// Register offsets, field positions and reset values of the servo I/O signal allocation block.
`ifndef SIA_REGS_VH
`define SIA_REGS_VH

// Register byte offsets on the AXI4-Lite bus.
`define SIA_OFF_OUT_INV        8'h00
`define SIA_OFF_OUT_SEL_FOUR   8'h04
`define SIA_OFF_IN_SEL_SEVEN   8'h08
`define SIA_OFF_IN_SEL_FIVE    8'h0C
`define SIA_OFF_CONTROL        8'h10
`define SIA_OFF_STATUS         8'h14
`define SIA_OFF_ACTIVE         8'h18

// Reset values of the setting registers.
`define SIA_RST_OUT_INV        16'h0000
`define SIA_RST_OUT_SEL_FOUR   16'h0000
`define SIA_RST_IN_SEL_SEVEN   16'h8888
`define SIA_RST_IN_SEL_FIVE    16'h8543

// Digit positions (low bit of each four-bit digit).
`define SIA_POS_INV_PAIR1      0
`define SIA_POS_INV_PAIR2      4
`define SIA_POS_INV_PAIR3      8
`define SIA_POS_MAINT_SEL      8
`define SIA_POS_FSTOP_SEL      0
`define SIA_POS_PROBE1_SEL     4
`define SIA_POS_PROBE2_SEL     8
`define SIA_POS_AUTO_DIGIT     12

// Value that the network side forces into the top digit of input selection five.
`define SIA_AUTO_DIGIT_VAL     4'h8

// Control register: writing one here restarts, loading settings into the routing.
`define SIA_CTRL_RESTART_BIT   0

// Forced-stop selection codes.
`define SIA_FSTOP_ALWAYS_STOP  4'h7
`define SIA_FSTOP_ALWAYS_RUN   4'h8
`define SIA_SEL_INVERT_BASE    4'h9

// AXI response codes.
`define SIA_RESP_OKAY          2'h0
`define SIA_RESP_SLVERR        2'h2

`endif

// File: hw/sia_in_sel.v
// Decoder that maps one input selection digit onto a terminal with polarity.
`include "sia_regs.vh"
`default_nettype none

module sia_in_sel #(
   parameter IS_FSTOP = 0                 // 1: forced-stop coding, 0: probe latch coding
) (
   input  wire [3:0] sel,                 // Selection digit
   input  wire [6:0] term,                // Synchronised terminals 7..13, one when closed
   output reg        active               // Resulting signal level
);

   reg [3:0] base;
   reg [2:0] idx;
   reg       hit;

   always @* begin
      base   = (sel >= `SIA_SEL_INVERT_BASE) ? sel - `SIA_SEL_INVERT_BASE : sel;
      // Code 0 names terminal 13; codes 1 to 6 name terminals 7 to 12.
      idx    = (base == 4'h0) ? 3'h6 : base[2:0] - 3'h1;
      hit    = term[idx];
      active = 1'b0;
      if (IS_FSTOP != 0) begin
         if (sel == `SIA_FSTOP_ALWAYS_STOP) begin
            active = 1'b0;                 // RULE_12
         end else if (sel == `SIA_FSTOP_ALWAYS_RUN) begin
            active = 1'b1;                 // RULE_13
         end else if (sel < `SIA_FSTOP_ALWAYS_STOP) begin
            active = hit;                  // RULE_11
         end else begin
            active = ~hit;                 // RULE_14
         end
      end else begin
         if (sel >= 4'h4 && sel <= 4'h6) begin
            active = hit;                  // RULE_01
         end else if (sel >= 4'hD) begin
            active = ~hit;                 // RULE_02
         end else begin
            active = 1'b0;                 // RULE_03
         end
      end
   end

endmodule

`default_nettype wire

// File: hw/sia_out_pair.v
// Output terminal pair driver: allocation match followed by inversion.
`default_nettype none

module sia_out_pair #(
   parameter [3:0] PAIR_CODE = 4'h1       // Allocation code that selects this pair
) (
   input  wire [3:0] pm_sel,              // Maintenance output allocation digit
   input  wire       pm_sig,              // Maintenance alert level
   input  wire       inv,                 // Inversion bit of this pair
   output wire       level                // Level driven to the terminal pair
);

   wire routed;

   // An unallocated pair carries an inactive level before inversion.
   assign routed = (pm_sel == PAIR_CODE) ? pm_sig : 1'b0;   // RULE_09
   assign level  = routed ^ inv;                             // RULE_18

endmodule

`default_nettype wire

// File: hw/sia_top.v
// Servo I/O signal allocation: AXI4-Lite settings, restart capture and terminal routing.
//
// Contract
// RULE_01: probe1 digit 4-6 follows closed terminals 10-12.
// RULE_02: probe1 digit D-F follows open terminals 10-12.
// RULE_03: other probe1 digit values keep probe inactive.
// RULE_04: probe2 decodes its digit like probe1.
// RULE_05: inversion digit 0 inverts pair 1/2.
// RULE_06: inversion digit 1 inverts pair 23/24.
// RULE_07: inversion digit 2 inverts pair 25/26.
// RULE_08: maintenance allocation 0 drives no pair.
// RULE_09: allocation 1-3 routes alert to pairs.
// RULE_10: software never writes reserved allocations 4-6.
// RULE_11: forced-stop 0-6 permits drive when terminal closed.
// RULE_12: forced-stop 7 always prohibits drive.
// RULE_13: forced-stop 8 always permits drive.
// RULE_14: forced-stop 9-F permits drive when terminal open.
// RULE_15: probe parameter top digit is forced to 8.
// RULE_16: software leaves reserved digits unchanged.
// RULE_17: settings reach routing only at restart.
// RULE_18: inversion follows allocation, before terminal drive.
`include "sia_regs.vh"
`default_nettype none

module sia_top (
   input  wire        aclk,               // Control clock, 125 MHz
   input  wire        aresetn,            // Synchronous reset, active low
   input  wire [7:0]  s_axi_awaddr,       // Write address
   input  wire        s_axi_awvalid,      // Write address valid
   output reg         s_axi_awready,      // Write address ready
   input  wire [31:0] s_axi_wdata,        // Write data
   input  wire [3:0]  s_axi_wstrb,        // Write byte strobes
   input  wire        s_axi_wvalid,       // Write data valid
   output reg         s_axi_wready,       // Write data ready
   output reg  [1:0]  s_axi_bresp,        // Write response
   output reg         s_axi_bvalid,       // Write response valid
   input  wire        s_axi_bready,       // Write response ready
   input  wire [7:0]  s_axi_araddr,       // Read address
   input  wire        s_axi_arvalid,      // Read address valid
   output reg         s_axi_arready,      // Read address ready
   output reg  [31:0] s_axi_rdata,        // Read data
   output reg  [1:0]  s_axi_rresp,        // Read response
   output reg         s_axi_rvalid,       // Read data valid
   input  wire        s_axi_rready,       // Read data ready
   input  wire [6:0]  io_connector_in,    // Input terminals 7..13, one when closed
   input  wire        maint_alert_in,     // Maintenance alert from drive logic
   output reg         probe_one_latch_input, // Probe 1 latch signal
   output reg         probe_two_latch_input, // Probe 2 latch signal
   output reg         drive_permit,       // Forced-stop result, one permits drive
   output reg  [2:0]  io_connector_out    // Pairs 1/2, 23/24, 25/26
);

   // Setting registers as software sees them.
   reg  [15:0] out_inv_q;
   reg  [15:0] out_sel_four_q;
   reg  [15:0] in_sel_seven_q;
   reg  [15:0] in_sel_five_q;

   // Settings that the routing actually uses.
   reg  [15:0] act_inv_q;
   reg  [15:0] act_sel_four_q;
   reg  [15:0] act_sel_seven_q;
   reg  [15:0] act_sel_five_q;
   reg         restart_q;

   // Two-stage synchroniser for the terminal pins.
   reg  [6:0]  term_meta_q;
   reg  [6:0]  term_q;

   // Write channel bookkeeping.
   reg         aw_got_q;
   reg         w_got_q;
   reg  [7:0]  awaddr_q;
   reg  [31:0] wdata_q;
   reg  [3:0]  wstrb_q;

   wire        probe1_d;
   wire        probe2_d;
   wire        permit_d;
   wire [2:0]  pair_d;
   wire [3:0]  pm_sel;
   wire        do_write;
   wire        wr_hit;
   wire [15:0] wr_val;
   reg  [31:0] rd_data;
   reg         rd_hit;

   assign pm_sel   = act_sel_four_q[`SIA_POS_MAINT_SEL +: 4];
   assign do_write = aw_got_q & w_got_q & ~s_axi_bvalid;
   assign wr_hit   = (awaddr_q[7:2] <= (`SIA_OFF_ACTIVE >> 2)) && (awaddr_q[1:0] == 2'h0)
                     && (awaddr_q != `SIA_OFF_STATUS) && (awaddr_q != `SIA_OFF_ACTIVE);

   // Applies byte strobes to the old value of the addressed 16-bit register.
   function [15:0] merge16;
      input [15:0] old;
      input [31:0] data;
      input [3:0]  strb;
      begin
         merge16 = old;
         if (strb[0]) begin
            merge16[7:0] = data[7:0];
         end
         if (strb[1]) begin
            merge16[15:8] = data[15:8];
         end
      end
   endfunction

   reg  [15:0] wr_old;

   always @* begin
      case (awaddr_q)
         `SIA_OFF_OUT_INV:      wr_old = out_inv_q;
         `SIA_OFF_OUT_SEL_FOUR: wr_old = out_sel_four_q;
         `SIA_OFF_IN_SEL_SEVEN: wr_old = in_sel_seven_q;
         `SIA_OFF_IN_SEL_FIVE:  wr_old = in_sel_five_q;
         default:               wr_old = 16'h0000;
      endcase
   end

   assign wr_val = merge16(wr_old, wdata_q, wstrb_q);

   // Write address and data are taken in either order; the response follows both.
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `SIA_RESP_OKAY;
         aw_got_q      <= 1'b0;
         w_got_q       <= 1'b0;
         awaddr_q      <= 8'h00;
         wdata_q       <= 32'h0000_0000;
         wstrb_q       <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_q      <= s_axi_awaddr;
            aw_got_q      <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
            w_got_q      <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `SIA_RESP_OKAY : `SIA_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            aw_got_q      <= 1'b0;
            w_got_q       <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Setting registers and the restart request.
   always @(posedge aclk) begin
      if (!aresetn) begin
         out_inv_q      <= `SIA_RST_OUT_INV;
         out_sel_four_q <= `SIA_RST_OUT_SEL_FOUR;
         in_sel_seven_q <= `SIA_RST_IN_SEL_SEVEN;
         in_sel_five_q  <= `SIA_RST_IN_SEL_FIVE;
         restart_q      <= 1'b0;
      end else begin
         restart_q <= 1'b0;
         if (do_write) begin
            case (awaddr_q)
               `SIA_OFF_OUT_INV:      out_inv_q      <= wr_val;
               `SIA_OFF_OUT_SEL_FOUR: out_sel_four_q <= wr_val;
               `SIA_OFF_IN_SEL_SEVEN: in_sel_seven_q <= wr_val;
               `SIA_OFF_IN_SEL_FIVE: begin
                  // The top digit belongs to the network side and is not user-settable.
                  in_sel_five_q <= {`SIA_AUTO_DIGIT_VAL, wr_val[11:0]}; // RULE_15
               end
               `SIA_OFF_CONTROL: begin
                  restart_q <= wstrb_q[0] & wdata_q[`SIA_CTRL_RESTART_BIT];
               end
               default: begin
               end
            endcase
         end
      end
   end

   // Writes to the settings do nothing to the routing until a restart; reset is one.
   always @(posedge aclk) begin
      if (!aresetn) begin
         act_inv_q       <= `SIA_RST_OUT_INV;      // RULE_17
         act_sel_four_q  <= `SIA_RST_OUT_SEL_FOUR;
         act_sel_seven_q <= `SIA_RST_IN_SEL_SEVEN;
         act_sel_five_q  <= `SIA_RST_IN_SEL_FIVE;
      end else if (restart_q) begin
         act_inv_q       <= out_inv_q;             // RULE_17
         act_sel_four_q  <= out_sel_four_q;
         act_sel_seven_q <= in_sel_seven_q;
         act_sel_five_q  <= in_sel_five_q;
      end
   end

   // Read channel: one read at a time, answered one cycle after the address is taken.
   always @* begin
      rd_hit  = 1'b1;
      rd_data = 32'h0000_0000;
      case (s_axi_araddr)
         `SIA_OFF_OUT_INV:      rd_data[15:0] = out_inv_q;
         `SIA_OFF_OUT_SEL_FOUR: rd_data[15:0] = out_sel_four_q;
         `SIA_OFF_IN_SEL_SEVEN: rd_data[15:0] = in_sel_seven_q;
         `SIA_OFF_IN_SEL_FIVE:  rd_data[15:0] = in_sel_five_q;
         `SIA_OFF_CONTROL:      rd_data = 32'h0000_0000;
         `SIA_OFF_STATUS: begin
            rd_data[0]     = probe_one_latch_input;
            rd_data[1]     = probe_two_latch_input;
            rd_data[2]     = drive_permit;
            rd_data[3]     = maint_alert_in;
            rd_data[6:4]   = io_connector_out;
            rd_data[13:7]  = term_q;
            // Set while stored settings differ from those in use, i.e. a restart is due.
            rd_data[14]    = (out_inv_q != act_inv_q) || (out_sel_four_q != act_sel_four_q)
                             || (in_sel_seven_q != act_sel_seven_q)
                             || (in_sel_five_q != act_sel_five_q);
         end
         `SIA_OFF_ACTIVE: begin
            rd_data[3:0]   = act_inv_q[`SIA_POS_INV_PAIR1 +: 4];
            rd_data[7:4]   = act_inv_q[`SIA_POS_INV_PAIR2 +: 4];
            rd_data[11:8]  = act_inv_q[`SIA_POS_INV_PAIR3 +: 4];
            rd_data[15:12] = pm_sel;
            rd_data[19:16] = act_sel_seven_q[`SIA_POS_FSTOP_SEL +: 4];
            rd_data[23:20] = act_sel_five_q[`SIA_POS_PROBE1_SEL +: 4];
            rd_data[27:24] = act_sel_five_q[`SIA_POS_PROBE2_SEL +: 4];
            rd_data[31:28] = act_sel_five_q[`SIA_POS_AUTO_DIGIT +: 4];
         end
         default: rd_hit = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `SIA_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_data;
            s_axi_rresp   <= rd_hit ? `SIA_RESP_OKAY : `SIA_RESP_SLVERR;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Terminal pins are asynchronous to aclk.
   always @(posedge aclk) begin
      if (!aresetn) begin
         term_meta_q <= 7'h00;
         term_q      <= 7'h00;
      end else begin
         term_meta_q <= io_connector_in;
         term_q      <= term_meta_q;
      end
   end

   sia_in_sel #(
      .IS_FSTOP (0)
   ) u_probe1 (
      .sel    (act_sel_five_q[`SIA_POS_PROBE1_SEL +: 4]),
      .term   (term_q),
      .active (probe1_d)
   );

   // Same decoder as probe 1, fed from its own digit.
   sia_in_sel #(
      .IS_FSTOP (0)
   ) u_probe2 (
      .sel    (act_sel_five_q[`SIA_POS_PROBE2_SEL +: 4]),  // RULE_04
      .term   (term_q),
      .active (probe2_d)
   );

   sia_in_sel #(
      .IS_FSTOP (1)
   ) u_fstop (
      .sel    (act_sel_seven_q[`SIA_POS_FSTOP_SEL +: 4]),
      .term   (term_q),
      .active (permit_d)
   );

   // Codes 0 and the reserved 4 to 6 match no pair, so no terminal carries the alert.
   sia_out_pair #(
      .PAIR_CODE (4'h1)
   ) u_pair1 (
      .pm_sel (pm_sel),                                     // RULE_08
      .pm_sig (maint_alert_in),
      .inv    (act_inv_q[`SIA_POS_INV_PAIR1]),              // RULE_05
      .level  (pair_d[0])
   );

   sia_out_pair #(
      .PAIR_CODE (4'h2)
   ) u_pair2 (
      .pm_sel (pm_sel),
      .pm_sig (maint_alert_in),
      .inv    (act_inv_q[`SIA_POS_INV_PAIR2]),              // RULE_06
      .level  (pair_d[1])
   );

   sia_out_pair #(
      .PAIR_CODE (4'h3)
   ) u_pair3 (
      .pm_sel (pm_sel),
      .pm_sig (maint_alert_in),
      .inv    (act_inv_q[`SIA_POS_INV_PAIR3]),              // RULE_07
      .level  (pair_d[2])
   );

   // Outputs are registered so that pins see no decode glitches.
   always @(posedge aclk) begin
      if (!aresetn) begin
         probe_one_latch_input <= 1'b0;
         probe_two_latch_input <= 1'b0;
         drive_permit          <= 1'b0;
         io_connector_out      <= 3'h0;
      end else begin
         probe_one_latch_input <= probe1_d;
         probe_two_latch_input <= probe2_d;
         drive_permit          <= permit_d;
         io_connector_out      <= pair_d;
      end
   end

endmodule

`default_nettype wire

// File: tb/sia_props.sv
// Checker of bus handshakes and terminal routing of the signal allocation block.
`default_nettype none
module sia_props (
   input wire logic        aclk,                  // Clock
   input wire logic        aresetn,               // Reset, active low
   input wire logic [7:0]  s_axi_awaddr,          // AW address
   input wire logic        s_axi_awvalid,         // AW valid
   input wire logic        s_axi_awready,         // AW ready
   input wire logic [31:0] s_axi_wdata,           // W data
   input wire logic        s_axi_wvalid,          // W valid
   input wire logic        s_axi_wready,          // W ready
   input wire logic        s_axi_bvalid,          // B valid
   input wire logic        s_axi_bready,          // B ready
   input wire logic        s_axi_arvalid,         // AR valid
   input wire logic        s_axi_arready,         // AR ready
   input wire logic [31:0] s_axi_rdata,           // R data
   input wire logic        s_axi_rvalid,          // R valid
   input wire logic        s_axi_rready,          // R ready
   input wire logic [6:0]  io_connector_in,       // Terminals
   input wire logic        maint_alert_in,        // Alert
   input wire logic        probe_one_latch_input, // Probe 1
   input wire logic        probe_two_latch_input, // Probe 2
   input wire logic        drive_permit,          // Permit
   input wire logic [2:0]  io_connector_out       // Pairs
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Shadow of written settings and of the copy taken at restart; full strobes assumed.
   localparam logic [18:0] DEF = 19'h00854;
   logic [18:0] sh_q, act_q;
   logic [7:0]  adr_q;
   logic [31:0] dat_q;
   logic [6:0]  in_q;
   logic        al_q;
   logic [2:0]  qt_q;
   // Bus or pin activity this cycle; outputs settle at most three edges after it.
   wire         busy = s_axi_awvalid || s_axi_wvalid || s_axi_bvalid
                       || in_q != io_connector_in || al_q != maint_alert_in;
   wire         ok = (qt_q == 3'h3) && !busy;
   wire  [3:0]  pm = act_q[15:12];
   wire  [2:0]  rt = {pm == 4'h3, pm == 4'h2, pm == 4'h1} & {3{maint_alert_in}};
   always_ff @(posedge aclk) begin
      in_q <= io_connector_in;
      al_q <= maint_alert_in;
      if (s_axi_awvalid && s_axi_awready) adr_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) dat_q <= s_axi_wdata;
      if (!aresetn) begin
         sh_q <= DEF;
         act_q <= DEF;
         qt_q <= 3'h0;
      end else begin
         if (s_axi_bvalid && s_axi_bready) begin
            case (adr_q)
               8'h00: sh_q[18:16] <= {dat_q[8], dat_q[4], dat_q[0]};
               8'h04: sh_q[15:12] <= dat_q[11:8];
               8'h08: sh_q[11:8] <= dat_q[3:0];
               8'h0C: sh_q[7:0] <= dat_q[11:4];
               8'h10: if (dat_q[0]) act_q <= sh_q;
               default: ;
            endcase
         end
         // Outputs are judged only once bus traffic and pins have been quiet a while.
         if (busy) qt_q <= 3'h0;
         else if (qt_q != 3'h3) qt_q <= qt_q + 3'h1;
      end
   end
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
      else $error("write not answered");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped early");
   a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready ##1 1'b1 |-> s_axi_rvalid)
      else $error("read not answered");
   a_fstop_stop: assert property (
      ok && act_q[11:8] == 4'h7 |-> !drive_permit) else $error("stop code permits drive");
   a_fstop_run: assert property (
      ok && act_q[11:8] == 4'h8 |-> drive_permit) else $error("run code forbids drive");
   a_probe_idle: assert property (
      ok && !(act_q[3:0] inside {4'h4, 4'h5, 4'h6, 4'hD, 4'hE, 4'hF})
      |-> !probe_one_latch_input) else $error("probe 1 active on idle code");
   a_probe_two_idle: assert property (
      ok && !(act_q[7:4] inside {4'h4, 4'h5, 4'h6, 4'hD, 4'hE, 4'hF})
      |-> !probe_two_latch_input) else $error("probe 2 active on idle code");
   a_out_route: assert property (
      ok |-> io_connector_out == (rt ^ act_q[18:16])) else $error("pair level wrong");
endmodule
`default_nettype wire

// File: tb/sia_term_model.sv
// Switches and sensors on the input terminals, loads on the output pairs.
`default_nettype none
module sia_term_model (
   input  wire logic       aclk,       // Clock
   input  wire logic [6:0] closed_cmd, // Contacts the bench closes
   input  wire logic [2:0] pair_level, // Levels on the output pairs
   output var  logic [6:0] term_level, // Terminal levels, one when closed
   output var  logic [2:0] load_on     // Loads energised
);
   timeunit 1ns;
   timeprecision 1ps;
   initial term_level = 7'h00;
   // Contacts move between clock edges, as a real switch is unrelated to the clock.
   always @(posedge aclk) term_level <= #3 closed_cmd;
   assign load_on = pair_level;
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Bench: register accesses, restart, and terminal routing against expected levels.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk = 1'b0, aresetn = 1'b0, maint_alert_in = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF, c2;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [6:0]  io_connector_in, pin_cmd = 7'h00;
   logic        probe_one_latch_input, probe_two_latch_input, drive_permit;
   logic [2:0]  io_connector_out, e;
   int          n_fail = 0, compares = 0, cyc = 0;
   sia_top u_sia_top (.*);
   sia_term_model u_sia_term_model (.aclk(aclk), .closed_cmd(pin_cmd),
      .pair_level(io_connector_out), .term_level(io_connector_in), .load_on());
   initial forever #4 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         results();
      end
   end
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      compares++;
      if (s !== x) begin
         n_fail++;
         $display("ERROR at %0t: seen %h expected %h", $time, s, x);
      end
   endtask
   // A late master raises its response ready only after it has seen the answer waiting.
   task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] xr,
                      input bit late = 1'b0);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= !late;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
      end while (!(s_axi_bvalid && s_axi_bready));
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, xr);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] xd, input logic [1:0] xr,
                      input bit late = 1'b0);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= !late;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
      end while (!(s_axi_rvalid && s_axi_rready));
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, xd);
      chk(s_axi_rresp, xr);
   endtask
   task automatic go();
      wrc(8'h10, 32'h1, 2'h0);
      repeat (4) @(posedge aclk);
   endtask
   task automatic pins(input logic [6:0] p);
      @(posedge aclk);
      pin_cmd <= p;
      repeat (6) @(posedge aclk);
   endtask
   // Terminal for codes 0..6, inverted sense for codes 9..F.
   function automatic logic ex(input logic [3:0] c, input logic [6:0] p);
      logic [3:0] k;
      k = (c > 4'h8) ? c - 4'h9 : c;
      ex = p[(k == 4'h0) ? 6 : k - 4'h1] ^ (c > 4'h8);
   endfunction
   function automatic logic pv(input logic [3:0] c, input logic [6:0] p);
      pv = (c inside {4'h4, 4'h5, 4'h6, 4'hD, 4'hE, 4'hF}) ? ex(c, p) : 1'b0;
   endfunction
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rdc(8'h00, 32'h0, 2'h0);
      rdc(8'h04, 32'h0, 2'h0);
      rdc(8'h08, 32'h8888, 2'h0);
      rdc(8'h0C, 32'h8543, 2'h0);
      rdc(8'h1C, 32'h0, 2'h2);
      wrc(8'h14, 32'h1, 2'h2, 1'b1);
      wrc(8'h0C, 32'h0543, 2'h0);
      rdc(8'h0C, 32'h8543, 2'h0);
      wrc(8'h08, 32'h8887, 2'h0);
      pins(7'h7F);
      chk(drive_permit, 1'b1);
      go();
      chk(drive_permit, 1'b0);
      for (int c = 0; c < 16; c++) begin
         c2 = 4'(c) ^ 4'h9;
         wrc(8'h08, {16'h0, 12'h888, 4'(c)}, 2'h0);
         wrc(8'h0C, {16'h0, 4'h8, c2, 4'(c), 4'h3}, 2'h0);
         go();
         for (int j = 0; j < 8; j++) begin
            pins(7'h1 << j);
            chk(drive_permit, (c == 7) ? 1'b0 : (c == 8) ? 1'b1 : ex(4'(c), pin_cmd));
            chk(probe_one_latch_input, pv(4'(c), pin_cmd));
            chk(probe_two_latch_input, pv(c2, pin_cmd));
         end
      end
      for (int m = 0; m < 4; m++) begin
         for (int i = 0; i < 8; i++) begin
            wrc(8'h04, 32'(m) << 8, 2'h0);
            wrc(8'h00, {23'h0, i[2], 3'h0, i[1], 3'h0, i[0]}, 2'h0);
            go();
            for (int a = 0; a < 2; a++) begin
               @(posedge aclk);
               maint_alert_in <= a[0];
               repeat (3) @(posedge aclk);
               e = {m == 3, m == 2, m == 1} & {3{a[0]}};
               chk(io_connector_out, e ^ 3'(i));
            end
         end
      end
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rdc(8'h08, 32'h8888, 2'h0);
      repeat (4) @(posedge aclk);
      chk(drive_permit, 1'b1);
      rdc(8'h18, 32'h8548_0000, 2'h0, 1'b1);
      rdc(8'h14, 32'h0000_000C, 2'h0);
      results();
   end
endmodule
bind sia_top sia_props u_sia_props (.*);
`default_nettype wire
